//--- verilog/bus_seq_map.svh
// bus_seq_map.svh: reset values, field widths and timing counts of the bus sequencer
// assumes it is included by bare name from design files that need these figures
`ifndef BUS_SEQ_MAP_SVH
`define BUS_SEQ_MAP_SVH

// clock periods that make up one microcycle phase
`define SEQ_CLKS_PER_PHASE   1
// width of the register-file index carried in the A field
`define SEQ_AFIELD_W         4
// width of the multiplexed address/data lines
`define SEQ_BUS_W            16
// width of one stored byte
`define SEQ_BYTE_W           8
// low byte position on the multiplexed lines
`define SEQ_LO_BYTE_LSB      0
// high byte position on the multiplexed lines
`define SEQ_HI_BYTE_LSB      8
// reset value of every control latch and request
`define SEQ_CTRL_RST         1'b0
// reset value of the driven word
`define SEQ_WORD_RST         16'h0000

`endif

//--- verilog/bus_seq_pkg.sv
// bus_seq_pkg: types shared by the phase generator and the bus sequencer
// assumes the map header supplies every number; only types live here
package bus_seq_pkg;

   // the four phases of a microcycle, in order
   typedef enum logic [1:0] {
      PHASE_1,
      PHASE_2,
      PHASE_3,
      PHASE_4
   } phase_t;

   // microinstruction class presented by the execution unit for a microcycle
   typedef enum logic [2:0] {
      OP_NONE,
      OP_READ_START,
      OP_READ_ACK,
      OP_INPUT_WORD,
      OP_OUTPUT_WORD,
      OP_OUTPUT_BYTE,
      OP_DATA_MANIP
   } op_t;

endpackage : bus_seq_pkg

//--- verilog/phase_gen.sv
// phase_gen: steps the four microcycle phases and flags the last clock of each
// assumes one free-running clock; phases advance every CLKS_PER_PHASE clocks
`timescale 1ns/1ps
`include "bus_seq_map.svh"

module phase_gen
   import bus_seq_pkg::*;
#(
   parameter int CLKS_PER_PHASE = `SEQ_CLKS_PER_PHASE
) (
   // clock and reset
   input  wire logic   ref_clk,
   input  wire logic   rst_b,
   // phase state
   output phase_t      phase_q,
   output logic        phaseEnd_q
);

   localparam int CW = (CLKS_PER_PHASE > 1) ? $clog2(CLKS_PER_PHASE) : 1;
   localparam logic [CW-1:0] LAST = CW'(CLKS_PER_PHASE - 1);
   localparam logic ONE_CLK = (CLKS_PER_PHASE == 1);

   generate
      if (CLKS_PER_PHASE < 1) begin : g_bad
         $error("phase_gen: CLKS_PER_PHASE must be at least 1");
      end
   endgenerate

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   phase_t        phase_d;

   // count within a phase, wrap and step the phase on its last clock
   assign cnt_d   = phaseEnd_q ? '0 : cnt_q + CW'(1);
   assign phase_d = phaseEnd_q ? phase_t'(phase_q + 2'd1) : phase_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q      <= '0;
         phase_q    <= PHASE_1;
         phaseEnd_q <= ONE_CLK;
      end else begin
         cnt_q      <= cnt_d;
         phase_q    <= phase_d;
         phaseEnd_q <= (cnt_d == LAST);   // registered so the edge decode is glitch free
      end
   end

endmodule : phase_gen

//--- verilog/rmw_and_intack_bus_sequencer.sv
// rmw_and_intack_bus_sequencer: bus control for read-modify-write and interrupt acknowledge
// assumes the execution unit holds op, rmwArg, aField and opWord steady through a
// microcycle and repeats a waiting microinstruction until opDone; bus inputs are
// synchronous to ref_clk; bus strobes are shown active high (asserted = 1).
//
// What this block does
// [RULE1] each microcycle is four phases; all bus transitions land on phase boundaries
// [RULE2] read-start completes at once when reply and busy are both clear at phase 3
// [RULE3] input op's B argument flags read-modify-write; frame held until output completes
// [RULE4] after read-start: address at phase 1, frame request phase 2, frame phase 4
// [RULE5] input op waits at phase 3 while reply is not seen, repeating each microcycle
// [RULE6] second microcycle after read-start: read request at phase 2, read strobe just after
// [RULE7] addressed slave answers read strobe with data and a reply
// [RULE8] slave reply is latched only at phase 1 start
// [RULE9] first pass stores low byte, next pass stores high byte to A field xor 1
// [RULE10] after input: read request and strobe drop at end of phase 1; frame stays in rmw
// [RULE11] slave removes data and reply when the read strobe drops
// [RULE12] data manipulation ops never test reply or busy, so never wait
// [RULE13] a negated reply clears the reply latch at next phase 1, clearing busy
// [RULE14] after output's failed check: write request and word at phase 1, strobe phase 3
// [RULE15] byte flag only for byte output, from strobe microcycle phase 1 to next phase 1
// [RULE16] slave takes the data on write strobe and then replies
// [RULE17] set reply latch drops write strobe at phase 3, after the phase 3 check sampled
// [RULE18] after output: frame request off phase 2, frame end and write off both at phase 4
// [RULE19] once the reply latch clears, the next op runs without waiting
// [RULE20] advice: avoid busy before read-start and reply checks right after output
// [RULE21] after read-ack: drive any register at phase 1, frame and ack requests at phase 2
// [RULE22] frame latch held reset while the acknowledge request is up
// [RULE23] interrupting slave replies only to grant; input op waits until then
// [RULE24] grant latch released by read request, then sets at trailing edge of phase 1
// [RULE25] only read and write group ops check busy; all others run immediately
`timescale 1ns/1ps
`include "bus_seq_map.svh"

module rmw_and_intack_bus_sequencer
   import bus_seq_pkg::*;
#(
   parameter int CLKS_PER_PHASE = `SEQ_CLKS_PER_PHASE,
   parameter int AFIELD_W       = `SEQ_AFIELD_W
) (
   // clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst_b,
   // microinstruction side
   input  wire op_t                       op,
   input  wire logic                      rmwArg,
   input  wire logic [AFIELD_W-1:0]       aField,
   input  wire logic [`SEQ_BUS_W-1:0]     opWord,
   output logic                           opDone,
   output logic                           opWait,
   output logic                           storeValid,
   output logic                           storeHigh,
   output logic [AFIELD_W-1:0]            storeReg,
   output logic [`SEQ_BYTE_W-1:0]         storeByte,
   output phase_t                         phaseNow,
   // internal requests
   output logic                           intFrameReq,
   output logic                           intReadReq,
   output logic                           intWriteReq,
   output logic                           intByteReq,
   output logic                           intIntrAckReq,
   // system bus
   input  wire logic [`SEQ_BUS_W-1:0]     muxedAddrDataIn,
   output logic [`SEQ_BUS_W-1:0]          muxedAddrDataOut,
   output logic                           muxedAddrDataOe,
   output logic                           busCycleFrame,
   output logic                           busReadStrobe,
   output logic                           busWriteStrobe,
   output logic                           busWriteByteFlag,
   output logic                           busIntrGrant,
   input  wire logic                      busSlaveReply
);

   generate
      if (AFIELD_W < 1) begin : g_bad
         $error("rmw_and_intack_bus_sequencer: AFIELD_W must be at least 1");
      end
   endgenerate

   logic phaseEnd;

   // phase stepping lives in its own module so the counter can be stretched
   phase_gen #(
      .CLKS_PER_PHASE (CLKS_PER_PHASE)
   ) u_phase (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .phase_q    (phaseNow),
      .phaseEnd_q (phaseEnd)
   );

   // edges that open each phase [RULE1]
   wire enterPh1 = phaseEnd && (phaseNow == PHASE_4);
   wire enterPh2 = phaseEnd && (phaseNow == PHASE_1);
   wire enterPh3 = phaseEnd && (phaseNow == PHASE_2);
   wire enterPh4 = phaseEnd && (phaseNow == PHASE_3);

   // sequencing state
   logic replyLatch_q;
   logic startDone_q;
   logic inDone_q;
   logic outDone_q;
   logic outFail_q;
   logic outByte_q;
   logic addrCycle_q;
   logic readCycle_q;
   logic afterIn_q;
   logic afterOut_q;
   logic highPending_q;
   logic ackMode_q;
   logic rmwMode_q;

   // op classes and the reply view seen by the phase 3 check
   wire isStart    = (op == OP_READ_START) || (op == OP_READ_ACK);
   wire isInput    = (op == OP_INPUT_WORD);
   wire isOutput   = (op == OP_OUTPUT_WORD) || (op == OP_OUTPUT_BYTE);
   wire busyFlag   = replyLatch_q;                            // [RULE13]
   wire replySeen  = replyLatch_q && (intReadReq || busWriteStrobe);
   // start ops need a quiet bus, transfer ops need the reply, others never test [RULE25]
   wire startPass  = !(busyFlag || replySeen);                // [RULE2] [RULE19]
   wire xferPass   = replySeen;                               // [RULE5] [RULE23]
   wire checkPass  = isStart ? startPass :
                     (isInput || isOutput) ? xferPass : 1'b1; // [RULE12]
   wire inFinish   = isInput && checkPass && highPending_q;
   wire outFinish  = isOutput && checkPass;
   wire outFirstNo = isOutput && !checkPass && !intWriteReq;
   wire endFrameIn = afterIn_q && !rmwMode_q;

   // reply latch only moves at phase 1 start; late replies wait a microcycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         replyLatch_q <= `SEQ_CTRL_RST;
      end else if (enterPh1) begin
         replyLatch_q <= busSlaveReply;                       // [RULE8] [RULE13]
      end
   end

   // phase 3 check results, cleared at the next phase 1 start except the byte flag
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         startDone_q <= `SEQ_CTRL_RST;
         inDone_q    <= `SEQ_CTRL_RST;
         outDone_q   <= `SEQ_CTRL_RST;
         outFail_q   <= `SEQ_CTRL_RST;
         outByte_q   <= `SEQ_CTRL_RST;
      end else if (enterPh3) begin
         startDone_q <= isStart && checkPass;                 // [RULE2]
         inDone_q    <= inFinish;
         outDone_q   <= outFinish;                            // [RULE3]
         outFail_q   <= outFirstNo;                           // [RULE14]
         outByte_q   <= (op == OP_OUTPUT_BYTE);
      end else if (enterPh1) begin
         startDone_q <= `SEQ_CTRL_RST;
         inDone_q    <= `SEQ_CTRL_RST;
         outDone_q   <= `SEQ_CTRL_RST;
         outFail_q   <= `SEQ_CTRL_RST;
      end
   end

   // microcycle stage flags, shifted at phase 1 start
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         addrCycle_q <= `SEQ_CTRL_RST;
         readCycle_q <= `SEQ_CTRL_RST;
         afterIn_q   <= `SEQ_CTRL_RST;
         afterOut_q  <= `SEQ_CTRL_RST;
      end else if (enterPh1) begin
         addrCycle_q <= startDone_q;                          // [RULE4] [RULE21]
         readCycle_q <= addrCycle_q;                          // [RULE6]
         afterIn_q   <= inDone_q;                             // [RULE10]
         afterOut_q  <= outDone_q;                            // [RULE18]
      end
   end

   // transaction modes: acknowledge and read-modify-write
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ackMode_q     <= `SEQ_CTRL_RST;
         rmwMode_q     <= `SEQ_CTRL_RST;
         highPending_q <= `SEQ_CTRL_RST;
      end else if (enterPh3) begin
         if (isStart && checkPass) begin
            ackMode_q <= (op == OP_READ_ACK);
         end
         if (isInput && rmwArg) begin
            rmwMode_q <= 1'b1;                                // [RULE3]
         end else if (outFinish) begin
            rmwMode_q <= 1'b0;                                // [RULE3]
         end
         if (isInput && checkPass) begin
            highPending_q <= !highPending_q;                  // [RULE9]
         end
      end
   end

   // frame and acknowledge requests change at phase 2 start
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         intFrameReq   <= `SEQ_CTRL_RST;
         intIntrAckReq <= `SEQ_CTRL_RST;
      end else if (enterPh2) begin
         if (addrCycle_q) begin
            intFrameReq   <= 1'b1;                            // [RULE4] [RULE21]
            intIntrAckReq <= ackMode_q;                       // [RULE21]
         end else if (afterOut_q || endFrameIn) begin
            intFrameReq   <= 1'b0;                            // [RULE18] [RULE10]
         end
         if (afterIn_q) begin
            intIntrAckReq <= 1'b0;
         end
      end
   end

   // frame latch: set at phase 4 start, reset only once the reply latch is clear;
   // the acknowledge request pins it low for the whole interrupt transaction
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busCycleFrame <= `SEQ_CTRL_RST;
      end else if (intIntrAckReq) begin
         busCycleFrame <= 1'b0;                               // [RULE22]
      end else if (enterPh4) begin
         if (intFrameReq) begin
            busCycleFrame <= 1'b1;                            // [RULE4]
         end else if (!replyLatch_q) begin
            busCycleFrame <= 1'b0;                            // [RULE18]
         end
      end
   end

   // read request: on at phase 2 of the read microcycle, off at end of phase 1 after input
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         intReadReq <= `SEQ_CTRL_RST;
      end else if (enterPh2 && readCycle_q) begin
         intReadReq <= 1'b1;                                  // [RULE6]
      end else if (enterPh2 && afterIn_q) begin
         intReadReq <= 1'b0;                                  // [RULE10]
      end
   end

   // read strobe trails the request by one clock but drops on the same edge
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busReadStrobe <= `SEQ_CTRL_RST;
      end else begin
         busReadStrobe <= intReadReq && !(enterPh2 && afterIn_q); // [RULE6] [RULE10]
      end
   end

   // grant latch held reset until a read request of an acknowledge is up
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busIntrGrant <= `SEQ_CTRL_RST;
      end else if (!intReadReq || !intIntrAckReq) begin
         busIntrGrant <= 1'b0;                                // [RULE24]
      end else if (enterPh2) begin
         busIntrGrant <= 1'b1;                                // [RULE24]
      end
   end

   // write and byte requests: on at phase 1 after the first failed output check
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         intWriteReq <= `SEQ_CTRL_RST;
         intByteReq  <= `SEQ_CTRL_RST;
      end else if (enterPh1 && outFail_q) begin
         intWriteReq <= 1'b1;                                 // [RULE14]
         intByteReq  <= outByte_q;                            // [RULE15]
      end else if (enterPh4 && afterOut_q) begin
         intWriteReq <= 1'b0;                                 // [RULE18]
         intByteReq  <= 1'b0;
      end
   end

   // byte flag spans exactly one microcycle from the strobe microcycle's phase 1
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busWriteByteFlag <= `SEQ_CTRL_RST;
      end else if (enterPh1) begin
         busWriteByteFlag <= outFail_q && outByte_q;          // [RULE15]
      end
   end

   // write strobe latch: set at phase 3 while no reply, reset at phase 3 once replied;
   // the check at the same edge still sees the old strobe, so the reply is not lost
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busWriteStrobe <= `SEQ_CTRL_RST;
      end else if (enterPh3) begin
         busWriteStrobe <= intWriteReq && !replyLatch_q && !afterOut_q; // [RULE14] [RULE17]
      end
   end

   // multiplexed lines: address or word out at phase 1, released for slave data
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         muxedAddrDataOe  <= `SEQ_CTRL_RST;
         muxedAddrDataOut <= `SEQ_WORD_RST;
      end else if (enterPh1 && (startDone_q || outFail_q)) begin
         muxedAddrDataOe  <= 1'b1;                            // [RULE4] [RULE14] [RULE21]
         muxedAddrDataOut <= opWord;
      end else if ((enterPh2 && readCycle_q) || (enterPh1 && afterOut_q)) begin
         muxedAddrDataOe  <= 1'b0;                            // [RULE18]
      end
   end

   // byte stores and completion report at the phase 3 check
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         storeValid <= `SEQ_CTRL_RST;
         storeHigh  <= `SEQ_CTRL_RST;
         storeReg   <= '0;
         storeByte  <= '0;
         opDone     <= `SEQ_CTRL_RST;
         opWait     <= `SEQ_CTRL_RST;
      end else if (enterPh3) begin
         storeValid <= isInput && checkPass;                  // [RULE9]
         storeHigh  <= highPending_q;
         storeReg   <= highPending_q ? (aField ^ AFIELD_W'(1)) : aField; // [RULE9]
         storeByte  <= highPending_q ? muxedAddrDataIn[`SEQ_HI_BYTE_LSB +: `SEQ_BYTE_W]
                                     : muxedAddrDataIn[`SEQ_LO_BYTE_LSB +: `SEQ_BYTE_W];
         opDone     <= checkPass && !(isInput && !highPending_q);
         opWait     <= !checkPass;                            // [RULE5] [RULE23]
      end else begin
         storeValid <= 1'b0;
         opDone     <= 1'b0;
      end
   end

endmodule : rmw_and_intack_bus_sequencer

//--- tb/rmw_seq_chk.sv
// rmw_seq_chk: port-level timing checks of the bus sequencer
// assumes CLKS_PER_PHASE of 1, so every phase lasts one ref_clk
`timescale 1ns/1ps
module rmw_seq_chk
   import bus_seq_pkg::*;
(
   // clock and reset
   input wire logic   ref_clk,
   input wire logic   rst_b,
   // sequencer outputs
   input wire phase_t phaseNow,
   input wire logic   opDone,
   input wire logic   intFrameReq,
   input wire logic   intReadReq,
   input wire logic   intWriteReq,
   input wire logic   intIntrAckReq,
   input wire logic   busCycleFrame,
   input wire logic   busReadStrobe,
   input wire logic   busWriteStrobe,
   input wire logic   busWriteByteFlag,
   input wire logic   busIntrGrant
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // first edge after reset still sees the reset phase, so it is skipped
   a_phase_step: assert property ($past(rst_b) |-> phaseNow == $past(phaseNow) + 2'h1)
      else $error("phase did not step by one");
   a_frame_open: assert property ($rose(busCycleFrame) |->
      phaseNow == PHASE_4 && intFrameReq && $past(intFrameReq, 2))
      else $error("frame rose outside phase 4");
   a_read_launch: assert property ($rose(intReadReq) |->
      phaseNow == PHASE_2 && !busReadStrobe ##1 busReadStrobe)
      else $error("read request or strobe mistimed");
   a_read_drop: assert property ($fell(intReadReq) |->
      phaseNow == PHASE_2 && $fell(busReadStrobe))
      else $error("read request drop mistimed");
   a_write_launch: assert property ($rose(intWriteReq) |->
      phaseNow == PHASE_1 ##2 $rose(busWriteStrobe) && phaseNow == PHASE_3)
      else $error("write request or strobe mistimed");
   a_byte_window: assert property ($rose(busWriteByteFlag) |->
      phaseNow == PHASE_1 ##1 busWriteByteFlag [*3] ##1 !busWriteByteFlag)
      else $error("byte flag window wrong");
   a_write_cut: assert property ($fell(busWriteStrobe) |->
      phaseNow == PHASE_3 ##[0:1] opDone)
      else $error("write strobe drop without completion");
   a_frame_close: assert property ($fell(intFrameReq) && busCycleFrame |->
      phaseNow == PHASE_2 ##1 busCycleFrame && intWriteReq
      ##1 !busCycleFrame && !intWriteReq && phaseNow == PHASE_4)
      else $error("frame close order wrong");
   a_ack_open: assert property ($rose(intIntrAckReq) |->
      phaseNow == PHASE_2 && $rose(intFrameReq))
      else $error("acknowledge request mistimed");
   a_ack_noframe: assert property (intIntrAckReq |-> !busCycleFrame)
      else $error("frame during acknowledge");
   a_grant_open: assert property ($rose(busIntrGrant) |->
      phaseNow == PHASE_2 && intReadReq && $past(intReadReq, 4))
      else $error("grant rose out of order");
endmodule : rmw_seq_chk

bind rmw_and_intack_bus_sequencer rmw_seq_chk chk_i (
   .ref_clk, .rst_b, .phaseNow, .opDone, .intFrameReq, .intReadReq, .intWriteReq,
   .intIntrAckReq, .busCycleFrame, .busReadStrobe, .busWriteStrobe, .busWriteByteFlag,
   .busIntrGrant
);

//--- tb/bus_slave_model.sv
// bus_slave_model: addressed or interrupting slave on the multiplexed bus
// assumes active-high strobes; lag sets the reply delay in clocks
`timescale 1ns/1ps
module bus_slave_model (
   // clock, reset and test controls
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [2:0]  lag,
   input  wire logic [15:0] rdWord,
   // bus side
   input  wire logic        busCycleFrame,
   input  wire logic        busReadStrobe,
   input  wire logic        busWriteStrobe,
   input  wire logic        busIntrGrant,
   input  wire logic [15:0] busLines,
   output logic [15:0]      slvLines,
   output logic             busSlaveReply,
   // what the slave saw
   output logic [15:0]      addrSeen,
   output logic [15:0]      wrSeen
);
   logic [2:0]  cnt_q;
   logic        drv_q;
   logic        frame_q;
   logic [15:0] last_q;
   wire         cause;
   // reads answer only in a framed cycle; vectors answer only to the grant
   assign cause = busWriteStrobe || busIntrGrant || (busReadStrobe && busCycleFrame);
   // released lines show the inverse of the last level, never a stale copy
   assign slvLines = drv_q ? rdWord : ~last_q;
   // reply after lag clocks; drop promptly when the cause goes away
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 3'h0;
         drv_q <= 1'b0;
         busSlaveReply <= 1'b0;
      end else if (!cause) begin
         cnt_q <= 3'h0;
         drv_q <= 1'b0;
         busSlaveReply <= 1'b0;
      end else if (cnt_q == lag) begin
         drv_q <= !busWriteStrobe;
         busSlaveReply <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end
   // capture address at frame start and write data when accepted
   always_ff @(posedge ref_clk) begin
      last_q <= busLines;
      frame_q <= busCycleFrame;
      if (busCycleFrame && !frame_q) addrSeen <= busLines;
      if (busWriteStrobe && cnt_q == lag) wrSeen <= busLines;
   end
endmodule : bus_slave_model

//--- tb/rmw_and_intack_bus_sequencer_tb_top.sv
// rmw_and_intack_bus_sequencer_tb_top: read-modify-write and acknowledge runs vs a model
// assumes the slave model on the bus and the bound checker; default phase length
`timescale 1ns/1ps
module rmw_and_intack_bus_sequencer_tb_top
   import bus_seq_pkg::*;
;
   logic ref_clk = 1'b0, rst_b = 1'b0, rmwArg = 1'b0, opDone, opWait, storeValid;
   logic storeHigh, intFrameReq, intReadReq, intWriteReq, intByteReq, intIntrAckReq;
   logic muxedAddrDataOe, busCycleFrame, busReadStrobe, busWriteStrobe, busWriteByteFlag;
   logic busIntrGrant, busSlaveReply;
   logic [3:0]  aField = 4'h0, storeReg, aV;
   logic [7:0]  storeByte;
   logic [15:0] opWord = 16'h0000, muxedAddrDataOut, slvLines, addrSeen, wrSeen, rdV;
   logic [15:0] rdWord = 16'h0000, busLines, addrV, wdV;
   logic [2:0]  lag = 3'h0;
   op_t         op = OP_NONE;
   phase_t      phaseNow;
   logic        rmwV;
   bit          doneS, byteS;
   int          err_total, n_tests, cyc, n;
   logic [15:0] expQ[$];
   // clock of 100 ns
   initial forever #50 ref_clk = ~ref_clk;
   // design drive wins when enabled, else whatever the slave leaves
   assign busLines = muxedAddrDataOe ? muxedAddrDataOut : slvLines;
   rmw_and_intack_bus_sequencer uut (.ref_clk(ref_clk), .rst_b(rst_b), .op(op),
      .rmwArg(rmwArg), .aField(aField), .opWord(opWord), .opDone(opDone), .opWait(opWait),
      .storeValid(storeValid), .storeHigh(storeHigh), .storeReg(storeReg),
      .storeByte(storeByte), .phaseNow(phaseNow), .intFrameReq(intFrameReq),
      .intReadReq(intReadReq), .intWriteReq(intWriteReq), .intByteReq(intByteReq),
      .intIntrAckReq(intIntrAckReq), .muxedAddrDataIn(busLines),
      .muxedAddrDataOut(muxedAddrDataOut), .muxedAddrDataOe(muxedAddrDataOe),
      .busCycleFrame(busCycleFrame), .busReadStrobe(busReadStrobe),
      .busWriteStrobe(busWriteStrobe), .busWriteByteFlag(busWriteByteFlag),
      .busIntrGrant(busIntrGrant), .busSlaveReply(busSlaveReply));
   bus_slave_model slave_i (.ref_clk(ref_clk), .rst_b(rst_b), .lag(lag), .rdWord(rdWord),
      .busCycleFrame(busCycleFrame), .busReadStrobe(busReadStrobe),
      .busWriteStrobe(busWriteStrobe), .busIntrGrant(busIntrGrant), .busLines(busLines),
      .slvLines(slvLines), .busSlaveReply(busSlaveReply), .addrSeen(addrSeen),
      .wrSeen(wrSeen));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // stores are checked against the model queue as they come out
   always @(negedge ref_clk) begin
      if (opDone) doneS = 1;
      if (intByteReq) byteS = 1;
      if (storeValid) chk({storeHigh, 3'h0, storeReg, storeByte},
         expQ.size() ? expQ.pop_front() : 16'hFFFF);
   end
   // hang guard; the whole run needs well under a thousand clocks
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         end_sim();
      end
   end
   // one microcycle: inputs change at phase 1 start, results gathered by phase 4
   task automatic mc(input op_t o, input logic [15:0] w);
      @(posedge ref_clk);
      op <= o;
      opWord <= w;
      rmwArg <= rmwV;
      aField <= aV;
      rdWord <= rdV;
      doneS = 0;
      repeat (4) @(negedge ref_clk);
      if (o > OP_INPUT_WORD) chk(16'(opWait), 16'(!doneS));
   endtask : mc
   // repeat a waiting op until it completes, as the executor would
   task automatic run(input op_t o, input logic [15:0] w);
      n = 0;
      do begin
         mc(o, w);
         n++;
      end while (!doneS && n < 12);
   endtask : run
   task automatic reset_dut;
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      chk({busCycleFrame, busReadStrobe, busWriteStrobe, intFrameReq, muxedAddrDataOe}, 0);
      do @(negedge ref_clk); while (phaseNow != PHASE_4);
   endtask : reset_dut
   initial begin
      void'($urandom(1766));
      reset_dut();
      for (int i = 0; i < 8; i++) begin
         lag <= 3'($urandom % 4);
         {rdV, addrV} = $urandom;
         {wdV, aV} = 20'($urandom);
         // random slow or prompt slave; each read-modify-write pass (i < 6) alternates the output width
         if (i < 6) begin
            rmwV = 1;
            run(OP_READ_START, addrV);
            chk(16'(n), 1);
            expQ.push_back({4'h0, aV, rdV[7:0]});
            expQ.push_back({4'h8, aV ^ 4'h1, rdV[15:8]});
            run(OP_INPUT_WORD, 16'h0000);
            chk(16'(n), 16'(4 + (lag != 0)));
            chk(addrSeen, addrV);
            byteS = 0;
            run(OP_DATA_MANIP, 16'h0000);
            chk({15'(n), intFrameReq}, 16'h0003);
            run(i[0] ? OP_OUTPUT_BYTE : OP_OUTPUT_WORD, wdV);
            chk(16'(n), 16'(3 + (lag != 0)));
            chk(wrSeen, wdV);
            chk(16'(byteS), 16'(i[0]));
            run(OP_NONE, 16'h0000);
            chk({busCycleFrame, intWriteReq, intFrameReq}, 0);
         end else begin
            rmwV = 0;
            run(OP_READ_ACK, addrV);
            chk(16'(n), 1);
            expQ.push_back({4'h0, aV, rdV[7:0]});
            expQ.push_back({4'h8, aV ^ 4'h1, rdV[15:8]});
            run(OP_INPUT_WORD, 16'h0000);
            chk(16'(n), 16'(5 + (lag > 1)));
            run(OP_NONE, 16'h0000);
            chk({busIntrGrant, intIntrAckReq, intReadReq}, 0);
         end
         chk(16'(expQ.size()), 0);
         $display("test %0d done", i);
         if (i == 5) reset_dut();
      end
      end_sim();
   end
endmodule : rmw_and_intack_bus_sequencer_tb_top
